/* sim/cri_monitor.sv */
module cri_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Link signals
  input wire logic req_valid,
  input wire logic req_ready,
  input wire cri_pkg::cri_req_type req_type,
  input wire logic rd_rsp_valid,
  input wire logic wr_rsp_valid,
  input wire cri_pkg::cri_rsp_type wr_rsp_kind,
  input wire logic dn_valid,
  input wire cri_pkg::cri_dn_type dn_type,
  input wire logic up_rsp_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_take(t);
    req_valid && req_ready && req_type == t;
  endsequence
  sequence s_wr(k);
    wr_rsp_valid && wr_rsp_kind == k;
  endsequence
  property p_rd_lat;
    s_take(cri_pkg::REQ_READ_INVALIDATE) |-> ##[3:60] rd_rsp_valid;
  endproperty
  property p_wr_lat;
    s_take(cri_pkg::REQ_WRITE_INVALIDATE) |-> ##[3:200] s_wr(cri_pkg::RSP_WRITE);
  endproperty
  property p_bar_lat;
    s_take(cri_pkg::REQ_WRITE_BARRIER) |-> ##[3:300] s_wr(cri_pkg::RSP_BARRIER);
  endproperty
  property p_int_lat;
    s_take(cri_pkg::REQ_INTERRUPT) |-> ##[3:300] s_wr(cri_pkg::RSP_INTERRUPT);
  endproperty
  property p_rd_pulse;
    rd_rsp_valid |=> !rd_rsp_valid;
  endproperty
  property p_wr_pulse;
    wr_rsp_valid |=> !wr_rsp_valid;
  endproperty
  property p_dn_read;
    dn_valid && dn_type == cri_pkg::DN_REG_READ |=> up_rsp_valid;
  endproperty
  property p_dn_other;
    dn_valid && dn_type != cri_pkg::DN_REG_READ |=> !up_rsp_valid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read unanswered");
  a_wr_lat: assert property (p_wr_lat) else $error("write unanswered");
  a_bar_lat: assert property (p_bar_lat) else $error("barrier unanswered");
  a_int_lat: assert property (p_int_lat) else $error("irq unanswered");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read rsp held");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write rsp held");
  a_dn_read: assert property (p_dn_read) else $error("reg read no data");
  a_dn_other: assert property (p_dn_other) else $error("spurious answer");
endmodule : cri_monitor

/* sim/test_coherent_request_ordering.sv */
module test_coherent_request_ordering;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset = 1'b1, cyc_valid, cyc_ack = 1'b0;
  logic cmd_valid = 1'b0, cmd_ready, cmd_reuse = 1'b1, rd_valid, wr_done;
  logic barrier_done, intr_done, msg_valid, msg_hint, host_valid = 1'b0;
  logic host_rsp_valid;
  logic [15:0] cyc_addr, cmd_addr = 16'h0, host_addr = 16'h1;
  logic [31:0] cyc_data, cyc_rd_data = 32'h0, cmd_data = 32'h0, rd_data;
  logic [31:0] host_data = 32'h0, host_rsp_data, msg_data, mem [16];
  cri_pkg::cri_cyc_type cyc_type;
  cri_pkg::cri_req_type cmd_type = cri_pkg::REQ_READ_INVALIDATE;
  cri_pkg::cri_chan_type cmd_chan = cri_pkg::CH_HIGH_A;
  cri_pkg::cri_dn_type host_type = cri_pkg::DN_REG_WRITE;
  int n_mismatch = 0, total_checks = 0;
  wire logic [3:0] done_vec = {rd_valid, wr_done, barrier_done, intr_done};
  cri_link_if link ();
  cri_host_interface_unit cri_host_interface_unit_inst (.ref_clk, .reset,
    .acc(link), .cyc_valid, .cyc_type, .cyc_addr, .cyc_data, .cyc_ack,
    .cyc_rd_data, .host_valid, .host_type, .host_addr, .host_data,
    .host_rsp_valid, .host_rsp_data);
  cri_accel_logic cri_accel_logic_inst (.ref_clk, .reset, .hiu(link),
    .cmd_valid, .cmd_ready, .cmd_type, .cmd_chan, .cmd_addr, .cmd_data,
    .cmd_reuse, .rd_valid, .rd_data, .wr_done, .barrier_done, .intr_done,
    .msg_valid, .msg_hint, .msg_data);
  cri_monitor cri_monitor_inst (.ref_clk, .reset, .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_type(link.req_type),
    .rd_rsp_valid(link.rd_rsp_valid), .wr_rsp_valid(link.wr_rsp_valid),
    .wr_rsp_kind(link.wr_rsp_kind), .dn_valid(link.dn_valid),
    .dn_type(link.dn_type), .up_rsp_valid(link.up_rsp_valid));
  always #20 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------------
  // Host memory: acks each link cycle one cycle after it appears
  // ----------------------------------------------------------------------
  initial for (int i = 0; i < 16; i++) mem[i] = 32'ha0 + i;
  always @(posedge ref_clk) begin
    cyc_ack <= cyc_valid && !cyc_ack;
    cyc_rd_data <= mem[cyc_addr[3:0]];
    if (cyc_valid && cyc_ack && (cyc_type == cri_pkg::CYC_WRITEBACK_TO_INVALID
        || cyc_type == cri_pkg::CYC_PUSHED_WRITEBACK)) begin
      mem[cyc_addr[3:0]] <= cyc_data;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic op(input cri_pkg::cri_req_type t, input logic [15:0] a,
      input logic [31:0] d, input int k);
    int i;
    @(posedge ref_clk);
    cmd_type <= t;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    for (i = 0; i < 300 && done_vec[k] !== 1'b1; i++) @(posedge ref_clk);
    check({31'h0, done_vec[k]}, 32'h1);
  endtask : op
  task automatic host(input cri_pkg::cri_dn_type t, input logic [31:0] d,
      input int n);
    @(posedge ref_clk);
    host_type <= t;
    host_data <= d;
    host_valid <= 1'b1;
    @(posedge ref_clk);
    host_valid <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : host
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    op(cri_pkg::REQ_WRITE_KEEP_MODIFIED, 16'h1, 32'h1111aaaa, 2);
    op(cri_pkg::REQ_READ_INVALIDATE, 16'h1, 32'h0, 3);
    check(rd_data, 32'h1111aaaa);
    $display("test modified hit done");
    op(cri_pkg::REQ_WRITE_INVALIDATE, 16'h2, 32'h2222bbbb, 2);
    op(cri_pkg::REQ_READ_INVALIDATE, 16'h2, 32'h0, 3);
    check(rd_data, 32'h2222bbbb);
    op(cri_pkg::REQ_READ_SHARED, 16'h3, 32'h0, 3);
    check(rd_data, 32'ha3);
    // Without reuse the shared read becomes an invalidating one and
    // evicts the Modified line at the same index first
    cmd_reuse <= 1'b0;
    op(cri_pkg::REQ_READ_SHARED, 16'h5, 32'h0, 3);
    check(rd_data, 32'ha5);
    check(mem[1], 32'h1111aaaa);
    cmd_reuse <= 1'b1;
    $display("test read and evict done");
    op(cri_pkg::REQ_WRITE_BARRIER, 16'h0, 32'h0, 1);
    op(cri_pkg::REQ_INTERRUPT, 16'h0, 32'h0, 0);
    $display("test barrier done");
    host(cri_pkg::DN_REG_WRITE, 32'h5a5a0001, 3);
    host(cri_pkg::DN_REG_READ, 32'h0, 3);
    check({31'h0, host_rsp_valid}, 32'h1);
    check(host_rsp_data, 32'h5a5a0001);
    host(cri_pkg::DN_USER_MESSAGE, 32'h77, 2);
    check(msg_data, 32'h77);
    $display("test host traffic done");
    close_out();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    close_out();
  end
endmodule : test_coherent_request_ordering

/* verilog/cri_accel_logic.sv */
module cri_accel_logic #(
  parameter int ADDR_W = cri_pkg::ADDR_W,
  parameter int DATA_W = cri_pkg::DATA_W,
  parameter int REGS = cri_pkg::ACC_REGS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Interface unit end
  cri_link_if.acc hiu,
  // Commands from user logic
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cri_pkg::cri_req_type cmd_type,
  input wire cri_pkg::cri_chan_type cmd_chan,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_data,
  input wire logic cmd_reuse,
  // Completions
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic wr_done,
  output logic barrier_done,
  output logic intr_done,
  // Host messages
  output logic msg_valid,
  output logic msg_hint,
  output logic [DATA_W-1:0] msg_data
);

  localparam int RIDX_W = (REGS > 1) ? $clog2(REGS) : 1;
  localparam int PW = cri_pkg::PEND_W;

  // ----------------------------------------------------------------------
  // Request shaping
  // ----------------------------------------------------------------------
  logic [PW-1:0] barrier_pending;
  logic wrote;
  logic mixed;
  cri_pkg::cri_chan_type last_chan;

  wire cmd_is_read = (cmd_type == cri_pkg::REQ_READ_INVALIDATE) ||
                     (cmd_type == cri_pkg::REQ_READ_SHARED);
  wire cmd_is_barrier = (cmd_type == cri_pkg::REQ_WRITE_BARRIER);
  // Reads wait out any barrier in flight, so they cannot see stale data.
  wire read_hold = cmd_is_read && (barrier_pending != '0);
  // Pending count saturating would lose a response, so a barrier is held
  // off the link while the counter is full.
  wire pend_full = (barrier_pending == {PW{1'b1}});
  wire hold = read_hold || (cmd_is_barrier && pend_full);
  wire cri_pkg::cri_chan_type barrier_chan = !wrote ? cmd_chan :
    mixed ? cri_pkg::CH_AUTO : last_chan;

  assign hiu.req_valid = cmd_valid && !hold;
  assign cmd_ready = hiu.req_ready && !hold;
  assign hiu.req_type = (cmd_type == cri_pkg::REQ_READ_SHARED && !cmd_reuse) ?
    cri_pkg::REQ_READ_INVALIDATE : cmd_type;
  assign hiu.req_chan = cmd_is_barrier ? barrier_chan : cmd_chan;
  assign hiu.req_addr = cmd_addr;
  assign hiu.req_data = cmd_data;

  wire fire = cmd_valid && cmd_ready;
  wire fire_barrier = fire && cmd_is_barrier;
  wire fire_ordered = fire && !cmd_is_read && !cmd_is_barrier;
  wire barrier_back = hiu.wr_rsp_valid &&
                      (hiu.wr_rsp_kind == cri_pkg::RSP_BARRIER);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      barrier_pending <= '0;
      wrote <= 1'b0;
      mixed <= 1'b0;
      last_chan <= cri_pkg::CH_AUTO;
    end else begin
      if (fire_barrier && !barrier_back) begin
        barrier_pending <= barrier_pending + 1'b1;
      end else if (barrier_back && !fire_barrier) begin
        barrier_pending <= barrier_pending - 1'b1;
      end
      if (fire_barrier) begin
        wrote <= 1'b0;
        mixed <= 1'b0;
      end else if (fire_ordered) begin
        wrote <= 1'b1;
        last_chan <= cmd_chan;
        if ((wrote && cmd_chan != last_chan) ||
            cmd_chan == cri_pkg::CH_AUTO) begin
          mixed <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Completions and host register space
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] regs [REGS];
  wire [RIDX_W-1:0] ridx = hiu.dn_addr[RIDX_W-1:0];
  wire dn_rd = hiu.dn_valid && (hiu.dn_type == cri_pkg::DN_REG_READ);
  wire dn_wr = hiu.dn_valid && (hiu.dn_type == cri_pkg::DN_REG_WRITE);
  wire dn_msg = hiu.dn_valid && !dn_rd && !dn_wr;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < REGS; i++) begin
        regs[i] <= '0;
      end
      hiu.up_rsp_valid <= 1'b0;
      hiu.up_rsp_data <= '0;
      msg_valid <= 1'b0;
      msg_hint <= 1'b0;
      msg_data <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      wr_done <= 1'b0;
      barrier_done <= 1'b0;
      intr_done <= 1'b0;
    end else begin
      if (dn_wr) begin
        regs[ridx] <= hiu.dn_data;
      end
      hiu.up_rsp_valid <= dn_rd;
      hiu.up_rsp_data <= regs[ridx];
      msg_valid <= dn_msg;
      msg_hint <= (hiu.dn_type == cri_pkg::DN_USER_MESSAGE_HINT);
      msg_data <= hiu.dn_data;
      rd_valid <= hiu.rd_rsp_valid;
      rd_data <= hiu.rd_rsp_data;
      wr_done <= hiu.wr_rsp_valid &&
                 (hiu.wr_rsp_kind == cri_pkg::RSP_WRITE);
      barrier_done <= barrier_back;
      intr_done <= hiu.wr_rsp_valid &&
                   (hiu.wr_rsp_kind == cri_pkg::RSP_INTERRUPT);
    end
  end

endmodule : cri_accel_logic

/* verilog/cri_host_interface_unit.sv */
module cri_host_interface_unit #(
  parameter int ADDR_W = cri_pkg::ADDR_W,
  parameter int DATA_W = cri_pkg::DATA_W,
  parameter int LINES = cri_pkg::CACHE_LINES,
  parameter int DEPTH = cri_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Accelerator end
  cri_link_if.hiu acc,
  // Link cycles
  output logic cyc_valid,
  output cri_pkg::cri_cyc_type cyc_type,
  output logic [ADDR_W-1:0] cyc_addr,
  output logic [DATA_W-1:0] cyc_data,
  input wire logic cyc_ack,
  input wire logic [DATA_W-1:0] cyc_rd_data,
  // Host register traffic
  input wire logic host_valid,
  input wire cri_pkg::cri_dn_type host_type,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [DATA_W-1:0] host_data,
  output logic host_rsp_valid,
  output logic [DATA_W-1:0] host_rsp_data
);

  localparam int IDX_W = (LINES > 1) ? $clog2(LINES) : 1;
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] BUF_FULL = (PTR_W+1)'(DEPTH);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic is_read(input cri_pkg::cri_req_type t);
    is_read = (t == cri_pkg::REQ_READ_INVALIDATE) ||
              (t == cri_pkg::REQ_READ_SHARED);
  endfunction : is_read

  function automatic logic is_write(input cri_pkg::cri_req_type t);
    is_write = (t == cri_pkg::REQ_WRITE_INVALIDATE) ||
               (t == cri_pkg::REQ_WRITE_KEEP_MODIFIED) ||
               (t == cri_pkg::REQ_WRITE_PUSH);
  endfunction : is_write

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  // ----------------------------------------------------------------------
  // Request intake: one read slot, ordered buffer for the rest
  // ----------------------------------------------------------------------
  // Reads get their own slot so queued writes never hold them back;
  // everything else keeps arrival order in the buffer.
  logic rd_full;
  cri_pkg::cri_req_type rd_type;
  cri_pkg::cri_chan_type rd_chan;
  logic [ADDR_W-1:0] rd_addr;
  cri_pkg::cri_req_type wq_type [DEPTH];
  cri_pkg::cri_chan_type wq_chan [DEPTH];
  logic [ADDR_W-1:0] wq_addr [DEPTH];
  logic [DATA_W-1:0] wq_data [DEPTH];
  logic [PTR_W-1:0] wq_wr;
  logic [PTR_W-1:0] wq_rd;
  logic [PTR_W:0] wq_count;

  cri_pkg::cri_state_type state;
  cri_pkg::cri_state_type next_state;

  wire in_read = is_read(acc.req_type);
  wire wq_full = (wq_count == BUF_FULL);
  assign acc.req_ready = in_read ? !rd_full : !wq_full;
  wire rd_push = acc.req_valid && acc.req_ready && in_read;
  wire wq_push = acc.req_valid && acc.req_ready && !in_read;
  wire start = (state == cri_pkg::ST_IDLE) &&
               (rd_full || (wq_count != '0));
  wire take_read = rd_full;
  wire wq_pop = start && !take_read;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_full <= 1'b0;
      wq_wr <= '0;
      wq_rd <= '0;
      wq_count <= '0;
    end else begin
      if (rd_push) begin
        rd_full <= 1'b1;
      end else if (start && take_read) begin
        rd_full <= 1'b0;
      end
      if (wq_push) begin
        wq_wr <= ptr_inc(wq_wr);
      end
      if (wq_pop) begin
        wq_rd <= ptr_inc(wq_rd);
      end
      if (wq_push && !wq_pop) begin
        wq_count <= wq_count + 1'b1;
      end else if (wq_pop && !wq_push) begin
        wq_count <= wq_count - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rd_push) begin
      rd_type <= acc.req_type;
      rd_chan <= acc.req_chan;
      rd_addr <= acc.req_addr;
    end
    if (wq_push) begin
      wq_type[wq_wr] <= acc.req_type;
      wq_chan[wq_wr] <= acc.req_chan;
      wq_addr[wq_wr] <= acc.req_addr;
      wq_data[wq_wr] <= acc.req_data;
    end
  end

  // ----------------------------------------------------------------------
  // Cache lookup and phase plan for the chosen request
  // ----------------------------------------------------------------------
  cri_pkg::cri_line_type line_state [LINES];
  logic [ADDR_W-1:0] line_addr [LINES];
  logic [DATA_W-1:0] line_data [LINES];

  wire cri_pkg::cri_req_type h_type = take_read ? rd_type : wq_type[wq_rd];
  wire cri_pkg::cri_chan_type h_chan = take_read ? rd_chan : wq_chan[wq_rd];
  wire [ADDR_W-1:0] h_addr = take_read ? rd_addr : wq_addr[wq_rd];
  wire [DATA_W-1:0] h_data = wq_data[wq_rd];
  wire [IDX_W-1:0] h_idx = h_addr[IDX_W-1:0];
  wire cri_pkg::cri_line_type l_st = line_state[h_idx];
  // Hit test is per address only; ordering never depends on it.
  wire hit = (l_st != cri_pkg::LINE_I) && (line_addr[h_idx] == h_addr);
  wire h_mem = is_read(h_type) || is_write(h_type);
  wire victim = h_mem && (l_st != cri_pkg::LINE_I) && !hit;
  wire h_shared = (h_type == cri_pkg::REQ_READ_SHARED);

  wire cri_pkg::cri_cyc_type plan_v = !victim ? cri_pkg::CYC_NONE :
    (l_st == cri_pkg::LINE_M) ? cri_pkg::CYC_WRITEBACK_TO_INVALID :
    cri_pkg::CYC_CLEAN_EVICT;
  wire cri_pkg::cri_cyc_type plan_f =
    is_read(h_type) ? (hit ? cri_pkg::CYC_NONE :
      (h_shared ? cri_pkg::CYC_CODE_READ :
       cri_pkg::CYC_CURRENT_READ)) :
    is_write(h_type) ? ((hit && l_st == cri_pkg::LINE_M) ?
      cri_pkg::CYC_NONE : cri_pkg::CYC_OWN_EXCLUSIVE) :
    (h_type == cri_pkg::REQ_WRITE_BARRIER) ?
      ((h_chan != cri_pkg::CH_LOW_LATENCY) ?
       cri_pkg::CYC_ZERO_LENGTH_FLUSH_READ : cri_pkg::CYC_NONE) :
    cri_pkg::CYC_INTERRUPT;
  wire cri_pkg::cri_cyc_type plan_p =
    (h_type == cri_pkg::REQ_WRITE_INVALIDATE) ?
      cri_pkg::CYC_WRITEBACK_TO_INVALID :
    (h_type == cri_pkg::REQ_WRITE_PUSH) ? cri_pkg::CYC_PUSHED_WRITEBACK :
    ((h_type == cri_pkg::REQ_WRITE_KEEP_MODIFIED) && victim) ?
      cri_pkg::CYC_WRITEBACK_TO_INVALID : cri_pkg::CYC_NONE;
  wire cri_pkg::cri_line_type plan_final =
    is_read(h_type) ? (hit ? l_st :
      (h_shared ? cri_pkg::LINE_S : cri_pkg::LINE_I)) :
    ((plan_p == cri_pkg::CYC_NONE) ? cri_pkg::LINE_M : cri_pkg::LINE_I);

  // ----------------------------------------------------------------------
  // Phase engine
  // ----------------------------------------------------------------------
  // One request at a time: every write except a REQ_WRITE_KEEP_MODIFIED needing no eviction is committed on the link before
  // the next buffered entry starts, which is what makes barriers cheap
  // here at the price of write throughput.
  cri_pkg::cri_cyc_type p_cyc_v;
  cri_pkg::cri_cyc_type p_cyc_f;
  cri_pkg::cri_cyc_type p_cyc_p;
  cri_pkg::cri_line_type p_final;
  cri_pkg::cri_req_type p_type;
  cri_pkg::cri_chan_type p_chan;
  logic p_read;
  logic p_upd;
  logic [IDX_W-1:0] p_idx;
  logic [ADDR_W-1:0] p_addr;
  logic [ADDR_W-1:0] v_addr;
  logic [DATA_W-1:0] v_data;
  logic [DATA_W-1:0] p_data;
  logic [DATA_W-1:0] rdata;

  wire cri_pkg::cri_cyc_type stage_cyc =
    (state == cri_pkg::ST_VICTIM) ? p_cyc_v :
    (state == cri_pkg::ST_FETCH) ? p_cyc_f :
    (state == cri_pkg::ST_POST) ? p_cyc_p : cri_pkg::CYC_NONE;
  wire stage_busy = (stage_cyc != cri_pkg::CYC_NONE);
  wire stage_done = !stage_busy || cyc_ack;

  always_comb begin
    next_state = state;
    unique case (state)
      cri_pkg::ST_IDLE: if (start) next_state = cri_pkg::ST_VICTIM;
      cri_pkg::ST_VICTIM: if (stage_done) next_state = cri_pkg::ST_FETCH;
      cri_pkg::ST_FETCH: if (stage_done) next_state = cri_pkg::ST_RESP;
      cri_pkg::ST_RESP: next_state = cri_pkg::ST_POST;
      cri_pkg::ST_POST: if (stage_done) next_state = cri_pkg::ST_IDLE;
      default: next_state = cri_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= cri_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      p_cyc_v <= cri_pkg::CYC_NONE;
      p_cyc_f <= cri_pkg::CYC_NONE;
      p_cyc_p <= cri_pkg::CYC_NONE;
      p_final <= cri_pkg::LINE_I;
      p_type <= cri_pkg::REQ_READ_INVALIDATE;
      p_chan <= cri_pkg::CH_AUTO;
      p_read <= 1'b0;
      p_upd <= 1'b0;
      p_idx <= '0;
      p_addr <= '0;
      v_addr <= '0;
      v_data <= '0;
      p_data <= '0;
      rdata <= '0;
    end else if (start) begin
      p_cyc_v <= plan_v;
      p_cyc_f <= plan_f;
      p_cyc_p <= plan_p;
      p_final <= plan_final;
      p_type <= h_type;
      p_chan <= h_chan;
      p_read <= is_read(h_type);
      p_upd <= h_mem;
      p_idx <= h_idx;
      p_addr <= h_addr;
      v_addr <= line_addr[h_idx];
      v_data <= line_data[h_idx];
      p_data <= h_data;
      rdata <= line_data[h_idx];
    end else if ((state == cri_pkg::ST_FETCH) && stage_busy && cyc_ack &&
                 p_read) begin
      rdata <= cyc_rd_data;
    end
  end

  // Line state is written once, when the last phase completes.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < LINES; i++) begin
        line_state[i] <= cri_pkg::LINE_I;
      end
    end else if ((state == cri_pkg::ST_POST) && stage_done && p_upd) begin
      line_state[p_idx] <= p_final;
      line_addr[p_idx] <= p_addr;
      line_data[p_idx] <= p_read ? rdata : p_data;
    end
  end

  // ----------------------------------------------------------------------
  // Link and response outputs
  // ----------------------------------------------------------------------
  assign cyc_valid = stage_busy;
  assign cyc_type = stage_cyc;
  assign cyc_addr = (state == cri_pkg::ST_VICTIM) ? v_addr : p_addr;
  assign cyc_data = (state == cri_pkg::ST_VICTIM) ? v_data : p_data;

  // Responses carry the request's own channel; auto-channel requests get
  // no stronger promise than that.
  wire in_resp = (state == cri_pkg::ST_RESP);
  assign acc.rd_rsp_valid = in_resp && p_read;
  assign acc.rd_rsp_data = rdata;
  assign acc.rd_rsp_chan = p_chan;
  assign acc.wr_rsp_valid = in_resp && !p_read;
  assign acc.wr_rsp_kind =
    (p_type == cri_pkg::REQ_WRITE_BARRIER) ? cri_pkg::RSP_BARRIER :
    (p_type == cri_pkg::REQ_INTERRUPT) ? cri_pkg::RSP_INTERRUPT :
    cri_pkg::RSP_WRITE;
  assign acc.wr_rsp_chan = p_chan;

  // ----------------------------------------------------------------------
  // Host register traffic, registered both ways
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acc.dn_valid <= 1'b0;
      acc.dn_type <= cri_pkg::DN_REG_READ;
      acc.dn_addr <= '0;
      acc.dn_data <= '0;
      host_rsp_valid <= 1'b0;
      host_rsp_data <= '0;
    end else begin
      acc.dn_valid <= host_valid;
      acc.dn_type <= host_type;
      acc.dn_addr <= host_addr;
      acc.dn_data <= host_data;
      host_rsp_valid <= acc.up_rsp_valid;
      host_rsp_data <= acc.up_rsp_data;
    end
  end

endmodule : cri_host_interface_unit

/* verilog/cri_link_if.sv */
interface cri_link_if #(
  parameter int ADDR_W = cri_pkg::ADDR_W,
  parameter int DATA_W = cri_pkg::DATA_W
);
  // Upstream requests
  logic req_valid;
  logic req_ready;
  cri_pkg::cri_req_type req_type;
  cri_pkg::cri_chan_type req_chan;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_data;
  // Read and write responses
  logic rd_rsp_valid;
  logic [DATA_W-1:0] rd_rsp_data;
  cri_pkg::cri_chan_type rd_rsp_chan;
  logic wr_rsp_valid;
  cri_pkg::cri_rsp_type wr_rsp_kind;
  cri_pkg::cri_chan_type wr_rsp_chan;
  // Downstream host register traffic
  logic dn_valid;
  cri_pkg::cri_dn_type dn_type;
  logic [ADDR_W-1:0] dn_addr;
  logic [DATA_W-1:0] dn_data;
  logic up_rsp_valid;
  logic [DATA_W-1:0] up_rsp_data;

  modport hiu (
    input req_valid, req_type, req_chan, req_addr, req_data,
    output req_ready,
    output rd_rsp_valid, rd_rsp_data, rd_rsp_chan,
    output wr_rsp_valid, wr_rsp_kind, wr_rsp_chan,
    output dn_valid, dn_type, dn_addr, dn_data,
    input up_rsp_valid, up_rsp_data
  );

  modport acc (
    output req_valid, req_type, req_chan, req_addr, req_data,
    input req_ready,
    input rd_rsp_valid, rd_rsp_data, rd_rsp_chan,
    input wr_rsp_valid, wr_rsp_kind, wr_rsp_chan,
    input dn_valid, dn_type, dn_addr, dn_data,
    output up_rsp_valid, up_rsp_data
  );
endinterface : cri_link_if

/* verilog/cri_pkg.sv */
package cri_pkg;

  // ----------------------------------------------------------------------
  // Default sizes
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int CACHE_LINES = 4;
  localparam int BUF_DEPTH = 2;
  localparam int ACC_REGS = 4;
  localparam int PEND_W = 4;

  // ----------------------------------------------------------------------
  // Upstream request kinds
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    REQ_WRITE_INVALIDATE = 3'h0,
    REQ_WRITE_KEEP_MODIFIED = 3'h1,
    REQ_WRITE_PUSH = 3'h2,
    REQ_READ_INVALIDATE = 3'h3,
    REQ_READ_SHARED = 3'h4,
    REQ_WRITE_BARRIER = 3'h5,
    REQ_INTERRUPT = 3'h6
  } cri_req_type;

  // ----------------------------------------------------------------------
  // Virtual channels
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CH_AUTO = 2'h0,
    CH_LOW_LATENCY = 2'h1,
    CH_HIGH_A = 2'h2,
    CH_HIGH_B = 2'h3
  } cri_chan_type;

  // ----------------------------------------------------------------------
  // Cache line states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LINE_I = 2'h0,
    LINE_S = 2'h1,
    LINE_M = 2'h2
  } cri_line_type;

  // ----------------------------------------------------------------------
  // Link cycles
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CYC_NONE = 4'h0,
    CYC_CODE_READ = 4'h1,
    CYC_CURRENT_READ = 4'h2,
    CYC_OWN_EXCLUSIVE = 4'h3,
    CYC_WRITEBACK_TO_INVALID = 4'h4,
    CYC_CLEAN_EVICT = 4'h5,
    CYC_PUSHED_WRITEBACK = 4'h6,
    CYC_ZERO_LENGTH_FLUSH_READ = 4'h7,
    CYC_INTERRUPT = 4'h8
  } cri_cyc_type;

  // ----------------------------------------------------------------------
  // Write response kinds and downstream request kinds
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSP_WRITE = 2'h0,
    RSP_BARRIER = 2'h1,
    RSP_INTERRUPT = 2'h2
  } cri_rsp_type;

  typedef enum logic [1:0] {
    DN_REG_READ = 2'h0,
    DN_REG_WRITE = 2'h1,
    DN_USER_MESSAGE = 2'h2,
    DN_USER_MESSAGE_HINT = 2'h3
  } cri_dn_type;

  // ----------------------------------------------------------------------
  // Engine states, Gray along the usual path from ST_IDLE up to ST_POST
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VICTIM = 3'b001,
    ST_FETCH = 3'b011,
    ST_RESP = 3'b010,
    ST_POST = 3'b110
  } cri_state_type;

endpackage : cri_pkg
